// ==== master_clock_source_select.sv ====
// Master clock source selector: picks the timing reference, derives the
// working sample rate, reports lock, and gates status after calibration.
// Assumes knob and switch pins are asynchronous, frame pulses come from the
// digital receivers on link_clk, and the clock mux follows ref_select.
`timescale 1ns/1ps
`include "mcs_consts.svh"

// Summary of operation
// - Five clock source settings, others ignored
// - Internal: ignore inputs, knob sets rate
// - Word 1 input is the reference
// - Word 2 input is the reference
// - Digital source: AES or S/PDIF per switch
// - Digital source: detected rate, knob ignored
// - Optical recovered clock is the reference
// - Word/optical: multiple of external rate
// - Clock source independent of DAC stream
// - Brief mute when a selection changes
// - Two second calibration before lamps
// - Green when locked, red otherwise
// - Six sample rate selections supported
// - Knob group times external rate family
// - Internal always locked; external needs clock
// - Switch engaged selects S/PDIF input
module master_clock_source_select #(
	parameter int unsigned CAL_CYCLES = `MCS_CAL_TIME_MS * `MCS_SYS_CLK_KHZ
) (
	input  wire logic           sys_clk,
	input  wire logic           rstn,
	input  wire logic           link_clk,
	input  wire logic [2:0]     clock_src_knob,
	input  wire logic [2:0]     rate_knob,
	input  wire logic           spdif_switch,
	input  wire logic           word1_in,
	input  wire logic           word2_in,
	input  wire logic           aes_frame,
	input  wire logic           spdif_frame,
	input  wire logic           optical_multichannel_input,
	output logic                power_lamp,
	output logic                status_green,
	output logic                status_red,
	output mcs_pkg::rate_e      master_rate,
	output mcs_pkg::src_e       ref_select,
	output logic                digital_use_spdif,
	output logic                int_osc_en,
	output logic                ref_locked,
	output logic                audio_mute
);
	import mcs_pkg::*;

	localparam int CAL_W = $clog2(CAL_CYCLES + 1);

	// ********************************************************************
	// Link domain: frame pulses become toggles
	// ********************************************************************
	logic aes_tgl_q;
	logic spdif_tgl_q;
	logic opt_tgl_q;

	// Toggles survive a stopped link clock; sys side sees each change once
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			aes_tgl_q   <= 1'b0;
			spdif_tgl_q <= 1'b0;
			opt_tgl_q   <= 1'b0;
		end else begin
			aes_tgl_q   <= aes_tgl_q ^ aes_frame;
			spdif_tgl_q <= spdif_tgl_q ^ spdif_frame;
			opt_tgl_q   <= opt_tgl_q ^ optical_multichannel_input;
		end
	end

	// ********************************************************************
	// Reference watchers, index order: word1, word2, aes, spdif, optical
	// ********************************************************************
	logic [`MCS_REF_COUNT-1:0] raw_ref;
	logic [`MCS_REF_COUNT-1:0] ev;
	logic [`MCS_REF_COUNT-1:0] pres;

	assign raw_ref = {opt_tgl_q, spdif_tgl_q, aes_tgl_q, word2_in, word1_in};

	// One watcher per reference; toggle streams count both edges
	genvar gi;
	generate
		for (gi = 0; gi < `MCS_REF_COUNT; gi++) begin : g_watch
			ref_watch #(
				.ANY_CHANGE (gi >= 2)
			) u_watch (
				.sys_clk   (sys_clk),
				.rstn      (rstn),
				.raw       (raw_ref[gi]),
				.ref_event (ev[gi]),
				.present   (pres[gi])
			);
		end
	endgenerate

	// ********************************************************************
	// Front-panel synchronisers
	// ********************************************************************
	logic [2:0] src_s1_q;
	logic [2:0] src_s2_q;
	logic [2:0] src_s3_q;
	logic [2:0] rate_s1_q;
	logic [2:0] rate_s2_q;
	logic [2:0] rate_s3_q;
	logic       sw_s1_q;
	logic       sw_s2_q;

	// Knobs are sampled once more so a half-turned code is never taken
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			src_s1_q  <= `MCS_RST_SRC;
			src_s2_q  <= `MCS_RST_SRC;
			src_s3_q  <= `MCS_RST_SRC;
			rate_s1_q <= `MCS_RST_RATE;
			rate_s2_q <= `MCS_RST_RATE;
			rate_s3_q <= `MCS_RST_RATE;
			sw_s1_q   <= 1'b0;
			sw_s2_q   <= 1'b0;
		end else begin
			src_s1_q  <= clock_src_knob;
			src_s2_q  <= src_s1_q;
			src_s3_q  <= src_s2_q;
			rate_s1_q <= rate_knob;
			rate_s2_q <= rate_s1_q;
			rate_s3_q <= rate_s2_q;
			sw_s1_q   <= spdif_switch;
			sw_s2_q   <= sw_s1_q;
		end
	end

	// ********************************************************************
	// Applied selections
	// ********************************************************************
	src_e  src_q;
	rate_e knob_rate_q;
	logic  use_spdif_q;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			src_q <= SRC_INTERNAL;
		end else if (src_s2_q == src_s3_q && src_s3_q <= 3'(SRC_OPTICAL)) begin
			src_q <= src_e'(src_s3_q);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			knob_rate_q <= R48K;
		end else if (rate_s2_q == rate_s3_q && rate_s3_q <= 3'(R192K)) begin
			knob_rate_q <= rate_e'(rate_s3_q);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			use_spdif_q <= 1'b0;
		end else begin
			use_spdif_q <= sw_s2_q;
		end
	end

	// ********************************************************************
	// Selected reference
	// ********************************************************************
	logic sel_ev;
	logic sel_pres;

	always_comb begin
		case (src_q)
			SRC_WORD1: begin
				sel_ev   = ev[0];
				sel_pres = pres[0];
			end
			SRC_WORD2: begin
				sel_ev   = ev[1];
				sel_pres = pres[1];
			end
			SRC_DIGITAL: begin
				sel_ev   = use_spdif_q ? ev[3] : ev[2];
				sel_pres = use_spdif_q ? pres[3] : pres[2];
			end
			SRC_OPTICAL: begin
				sel_ev   = ev[4];
				sel_pres = pres[4];
			end
			default: begin
				sel_ev   = 1'b0;
				sel_pres = 1'b0;
			end
		endcase
	end

	// ********************************************************************
	// Reference rate measurement
	// ********************************************************************
	logic [10:0] per_q;
	rate_e       det_rate_q;
	src_e        prev_src_q;
	logic        prev_spdif_q;

	// Map one frame period onto the nearest standard rate
	function automatic rate_e classify(input logic [10:0] per);
		rate_e r;
		if (per > `MCS_LIM_44K1) begin
			r = R44K1;
		end else if (per > `MCS_LIM_48K) begin
			r = R48K;
		end else if (per > `MCS_LIM_88K2) begin
			r = R88K2;
		end else if (per > `MCS_LIM_96K) begin
			r = R96K;
		end else if (per > `MCS_LIM_176K4) begin
			r = R176K4;
		end else begin
			r = R192K;
		end
		return r;
	endfunction : classify

	// Previous selection, used to spot changes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prev_src_q   <= SRC_INTERNAL;
			prev_spdif_q <= 1'b0;
		end else begin
			prev_src_q   <= src_q;
			prev_spdif_q <= use_spdif_q;
		end
	end

	logic ref_changed;
	assign ref_changed = (src_q != prev_src_q) || (use_spdif_q != prev_spdif_q);

	// Period counter restarts on a new reference so old timing is not mixed in
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			per_q      <= 11'h0000;
			det_rate_q <= R48K;
		end else if (ref_changed) begin
			per_q      <= 11'h0000;
		end else if (sel_ev) begin
			per_q      <= 11'h0001;
			if (per_q != 11'h0000 && per_q != `MCS_PER_MAX) begin
				det_rate_q <= classify(per_q);
			end
		end else if (per_q != 11'h0000 && per_q != `MCS_PER_MAX) begin // Idle until the first edge
			per_q      <= per_q + 11'h0001;
		end
	end

	// ********************************************************************
	// Working sample rate
	// ********************************************************************
	rate_e rate_d;
	rate_e rate_q;

	always_comb begin
		case (src_q)
			SRC_INTERNAL: begin
				rate_d = knob_rate_q;
			end
			SRC_DIGITAL: begin
				rate_d = sel_pres ? det_rate_q : rate_q;
			end
			SRC_WORD1, SRC_WORD2, SRC_OPTICAL: begin
				rate_d = sel_pres ? rate_e'({knob_rate_q[2:1], det_rate_q[0]}) : rate_q;
			end
			default: begin
				rate_d = knob_rate_q;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rate_q <= R48K;
		end else begin
			rate_q <= rate_d;
		end
	end

	// ********************************************************************
	// Calibration and selection-change sequencing
	// ********************************************************************
	run_state_e  state_q;
	logic [CAL_W-1:0] cal_q;
	logic [11:0] mute_q;
	logic        sel_changed;

	assign sel_changed = ref_changed || (rate_d != rate_q);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_CAL;
			cal_q   <= '0;
			mute_q  <= 12'h0000;
		end else begin
			case (state_q)
				ST_CAL: begin
					if (cal_q == CAL_W'(CAL_CYCLES - 1)) begin
						state_q <= ST_RUN;
					end else begin
						cal_q <= cal_q + CAL_W'(1);
					end
				end
				ST_RUN: begin
					if (sel_changed) begin
						state_q <= ST_SWITCH;
						mute_q  <= 12'h0000;
					end
				end
				ST_SWITCH: begin
					// A further change restarts the mute window
					if (sel_changed) begin
						mute_q  <= 12'h0000;
					end else if (mute_q == 12'(`MCS_MUTE_CYC - 1)) begin
						state_q <= ST_RUN;
					end else begin
						mute_q  <= mute_q + 12'h0001;
					end
				end
				default: begin
					state_q <= ST_CAL;
				end
			endcase
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	logic lock_d;

	assign lock_d = (src_q == SRC_INTERNAL) ? 1'b1 : sel_pres;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			power_lamp   <= 1'b0;
			status_green <= 1'b0;
			status_red   <= 1'b0;
			ref_locked   <= 1'b0;
			audio_mute   <= 1'b1;
		end else begin
			power_lamp   <= (state_q != ST_CAL);
			status_green <= (state_q != ST_CAL) && lock_d;
			status_red   <= (state_q != ST_CAL) && !lock_d;
			ref_locked   <= lock_d;
			audio_mute   <= (state_q != ST_RUN) || sel_changed || !lock_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ref_select        <= SRC_INTERNAL;
			digital_use_spdif <= 1'b0;
			int_osc_en        <= 1'b1;
			master_rate       <= R48K;
		end else begin
			ref_select        <= src_q;
			digital_use_spdif <= use_spdif_q;
			int_osc_en        <= (src_q == SRC_INTERNAL);
			master_rate       <= rate_q;
		end
	end

endmodule : master_clock_source_select

// ==== master_clock_source_select_tb.sv ====
// Bench for the master clock source selector, one task per scenario.
// Assumes ref_sources drives the reference pins; knobs change at falling edges.
`timescale 1ns/1ps

// ********************************************************************
// Testbench top
// ********************************************************************
module master_clock_source_select_tb;
	import mcs_pkg::*;
	localparam int unsigned CAL = 200;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b1;
	logic [2:0]  src = 3'h0;
	logic [2:0]  rate = 3'h1;
	logic        sw = 1'b0;
	logic [4:0]  en = 5'h00;
	logic        link_clk, w1, w2, af, sf, of, pl, sg, sr, de, oe, lk, mu;
	rate_e       mr;
	src_e        rs;
	int          fail_count = 0;
	int          compares = 0;
	int          cyc = 0;

	ref_sources u_src (.en(en), .link_clk(link_clk), .word1_in(w1), .word2_in(w2), .aes_frame(af),
		.spdif_frame(sf), .optical_multichannel_input(of));
	master_clock_source_select #(.CAL_CYCLES(CAL)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
		.link_clk(link_clk), .clock_src_knob(src), .rate_knob(rate), .spdif_switch(sw),
		.word1_in(w1), .word2_in(w2), .aes_frame(af), .spdif_frame(sf),
		.optical_multichannel_input(of), .power_lamp(pl), .status_green(sg), .status_red(sr),
		.master_rate(mr), .ref_select(rs), .digital_use_spdif(de), .int_osc_en(oe),
		.ref_locked(lk), .audio_mute(mu));

	// 40 MHz system clock
	always #12.5 sys_clk = ~sys_clk;

	// Hang guard, well above the 40k cycles the scenarios need
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			test_done();
		end
	end

	task automatic chk_v(input logic [2:0] exp, input logic [2:0] act);
		compares++;
		if (act !== exp) begin
			fail_count++;
			$display("wrong value at %0t: expected %h got %h", $time, exp, act);
		end
	endtask : chk_v

	task automatic chk_b(input logic exp, input logic act);
		chk_v({2'b00, exp}, {2'b00, act});
	endtask : chk_b

	// Set knobs and switch, then let n cycles pass
	task automatic go(input logic [2:0] s, input logic [2:0] r, input logic w, input int n);
		@(negedge sys_clk);
		src = s;
		rate = r;
		sw = w;
		repeat (n) @(negedge sys_clk);
	endtask : go

	task automatic t_cal();
		repeat (100) @(negedge sys_clk);
		chk_b(1'b0, pl);
		chk_b(1'b0, sg | sr);
		go(3'h0, 3'h1, 1'b0, CAL);
		chk_b(1'b1, pl);
		chk_b(1'b1, sg);
		chk_b(1'b0, sr);
		chk_b(1'b1, oe);
		$display("test cal done");
	endtask : t_cal

	task automatic t_int();
		for (int r = 0; r < 6; r++) begin
			go(3'h0, r[2:0], 1'b0, 12);
			chk_v(r[2:0], mr);
		end
		go(3'h0, 3'h7, 1'b0, 12);
		chk_v(R192K, mr);
		go(3'h7, 3'h5, 1'b0, 12);
		chk_v(SRC_INTERNAL, rs);
		$display("test internal done");
	endtask : t_int

	// Knob is set before the source, so the held rate already has its group
	task automatic t_word();
		en[0] = 1'b1;
		go(3'h0, 3'h3, 1'b0, 12);
		go(3'h1, 3'h3, 1'b0, 6000);
		chk_v(SRC_WORD1, rs);
		chk_v(R88K2, mr);
		chk_b(1'b1, sg);
		chk_b(1'b0, mu | oe);
		go(3'h5, 3'h5, 1'b0, 12);
		chk_v(SRC_WORD1, rs);
		chk_b(1'b1, mu);
		en[1] = 1'b1;
		go(3'h2, 3'h5, 1'b0, 6000);
		chk_v(SRC_WORD2, rs);
		chk_v(R192K, mr);
		go(3'h2, 3'h0, 1'b0, 12);
		chk_v(R48K, mr);
		$display("test word done");
	endtask : t_word

	task automatic t_opt();
		en[4] = 1'b1;
		go(3'h2, 3'h1, 1'b0, 12);
		go(3'h4, 3'h1, 1'b0, 6000);
		chk_v(SRC_OPTICAL, rs);
		chk_b(1'b1, lk);
		go(3'h4, 3'h2, 1'b0, 12);
		chk_v(R96K, mr);
		$display("test optical done");
	endtask : t_opt

	// Knob ends in the 88.2/96 group to match the next word source
	task automatic t_dig();
		en[3] = 1'b1;
		go(3'h3, 3'h0, 1'b1, 6000);
		chk_v(R96K, mr);
		chk_b(1'b1, de);
		chk_b(1'b1, sg);
		go(3'h3, 3'h2, 1'b0, 5000);
		chk_b(1'b0, de);
		chk_b(1'b0, lk);
		chk_b(1'b1, sr);
		en[2] = 1'b1;
		go(3'h3, 3'h2, 1'b0, 2000);
		chk_b(1'b1, lk);
		chk_v(R96K, mr);
		$display("test digital done");
	endtask : t_dig

	task automatic t_loss();
		go(3'h1, 3'h2, 1'b0, 3000);
		chk_b(1'b1, lk);
		en = 5'h00;
		repeat (4500) @(negedge sys_clk);
		chk_b(1'b0, lk);
		chk_b(1'b1, sr);
		$display("test loss done");
	endtask : t_loss

	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done

	// Reset for 10 cycles, then the scenarios in order; the falling edge of
	// rstn also clears the link-side flops while their clock is at rest
	initial begin
		@(negedge sys_clk);
		rstn = 1'b0;
		repeat (10) @(negedge sys_clk);
		rstn = 1'b1;
		t_cal();
		t_int();
		t_word();
		t_opt();
		t_dig();
		t_loss();
		test_done();
	end
endmodule : master_clock_source_select_tb

// ==== mcs_checker_properties.sv ====
// Checker on the ports of the master clock source selector.
// Assumes it is bound into every selector instance.
`timescale 1ns/1ps

// ********************************************************************
// Port checker
// ********************************************************************
module mcs_checker #(
	parameter int unsigned CAL_CYCLES = 80000000
) (
	input wire logic           sys_clk,
	input wire logic           rstn,
	input wire logic [2:0]     rate_knob,
	input wire logic           spdif_switch,
	input wire logic           power_lamp,
	input wire logic           status_green,
	input wire logic           status_red,
	input wire mcs_pkg::rate_e master_rate,
	input wire mcs_pkg::src_e  ref_select,
	input wire logic           digital_use_spdif,
	input wire logic           ref_locked,
	input wire logic           audio_mute
);
	import mcs_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	logic [31:0] cnt_q;

	// Cycles since reset; saturates so a long run never wraps
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 32'h0000_0000;
		end else if (cnt_q != 32'hffff_ffff) begin
			cnt_q <= cnt_q + 32'h0000_0001;
		end
	end

	// Knob held and valid while the internal source runs
	sequence s_int_steady;
		(ref_select == SRC_INTERNAL && $stable(rate_knob) && rate_knob < 3'h6)[*8];
	endsequence
	// Knob held while a locked word or optical source runs
	sequence s_ext_steady;
		(ref_locked && ref_select inside {SRC_WORD1, SRC_WORD2, SRC_OPTICAL} && $stable(rate_knob)
			&& rate_knob < 3'h6)[*8];
	endsequence

	property p_cal_len;
		$rose(power_lamp) |-> cnt_q >= CAL_CYCLES && cnt_q <= CAL_CYCLES + 4;
	endproperty
	a_cal_len: assert property (p_cal_len) else $error("power lamp at wrong time");
	property p_cal_dark;
		!power_lamp |-> !status_green && !status_red;
	endproperty
	a_cal_dark: assert property (p_cal_dark) else $error("status lit during calibration");
	property p_lamp;
		(power_lamp && $stable(ref_locked))[*3] |-> status_green == ref_locked && status_red == !ref_locked;
	endproperty
	a_lamp: assert property (p_lamp) else $error("status lamp disagrees with lock");
	property p_int_lock;
		(ref_select == SRC_INTERNAL)[*4] |-> ref_locked;
	endproperty
	a_int_lock: assert property (p_int_lock) else $error("internal source not locked");
	property p_int_rate;
		s_int_steady |-> master_rate == rate_knob;
	endproperty
	a_int_rate: assert property (p_int_rate) else $error("internal rate differs from knob");
	property p_ext_rate;
		s_ext_steady |-> master_rate[2:1] == rate_knob[2:1];
	endproperty
	a_ext_rate: assert property (p_ext_rate) else $error("external rate group differs from knob");
	property p_mute;
		$changed(ref_select) |-> ##[0:1] audio_mute;
	endproperty
	a_mute: assert property (p_mute) else $error("no mute on source change");
	property p_spdif;
		(ref_select == SRC_DIGITAL && $stable(spdif_switch))[*8] |-> digital_use_spdif == spdif_switch;
	endproperty
	a_spdif: assert property (p_spdif) else $error("digital input choice differs from switch");
endmodule : mcs_checker

bind master_clock_source_select mcs_checker #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.sys_clk, .rstn,
	.rate_knob, .spdif_switch, .power_lamp, .status_green, .status_red, .master_rate, .ref_select,
	.digital_use_spdif, .ref_locked, .audio_mute);

// ==== mcs_consts.svh ====
// Timing constants and reset values for the master clock source selector.
// Assumes the system clock of 40 MHz; the mute count is derived from it here, the period classes are fixed for it.
`ifndef MCS_CONSTS_SVH
`define MCS_CONSTS_SVH

// ********************************************************************
// System clock
// ********************************************************************
`define MCS_SYS_CLK_KHZ        40000

// ********************************************************************
// Power-on calibration and selection-change mute
// ********************************************************************
`define MCS_CAL_TIME_MS        2000
`define MCS_MUTE_TIME_US       100
`define MCS_MUTE_CYC           ((`MCS_MUTE_TIME_US * `MCS_SYS_CLK_KHZ + 999) / 1000)

// ********************************************************************
// Reference period classes, in system clock cycles per frame
// ********************************************************************
`define MCS_PER_44K1           907
`define MCS_LIM_44K1           11'h0366
`define MCS_LIM_48K            11'h0271
`define MCS_LIM_88K2           11'h01B3
`define MCS_LIM_96K            11'h0141
`define MCS_LIM_176K4          11'h00D9
`define MCS_PER_MAX            11'h07FF

// ********************************************************************
// Loss-of-clock timeout: several periods of the slowest reference
// ********************************************************************
`define MCS_REF_TIMEOUT_PERIODS 4
`define MCS_REF_TIMEOUT_CYC    (`MCS_REF_TIMEOUT_PERIODS * `MCS_PER_44K1)
`define MCS_REF_COUNT          5

// ********************************************************************
// Reset values
// ********************************************************************
`define MCS_RST_RATE           3'h1
`define MCS_RST_SRC            3'h0

`endif

// ==== mcs_pkg.sv ====
// Types shared by the master clock source selector, its checker and its testbench.
// Assumes nothing beyond a SystemVerilog compiler.
package mcs_pkg;

	// Sample rates; bit 0 is the family, bits 2:1 the multiple group
	typedef enum logic [2:0] {
		R44K1  = 3'h0,
		R48K   = 3'h1,
		R88K2  = 3'h2,
		R96K   = 3'h3,
		R176K4 = 3'h4,
		R192K  = 3'h5
	} rate_e;

	// Master clock source settings
	typedef enum logic [2:0] {
		SRC_INTERNAL = 3'h0,
		SRC_WORD1    = 3'h1,
		SRC_WORD2    = 3'h2,
		SRC_DIGITAL  = 3'h3,
		SRC_OPTICAL  = 3'h4
	} src_e;

	// Run state, Gray coded along calibrate, run, switch
	typedef enum logic [1:0] {
		ST_CAL    = 2'b00,
		ST_RUN    = 2'b01,
		ST_SWITCH = 2'b11
	} run_state_e;

endpackage : mcs_pkg

// ==== ref_sources.sv ====
// Model of the studio clock sources and digital receivers at the far side.
// Assumes the bench switches each source through en; word1, word2, aes, spdif, optical.
`timescale 1ns/1ps

// ********************************************************************
// Reference sources
// ********************************************************************
module ref_sources (
	input  wire logic [4:0] en,
	output logic            link_clk,
	output logic            word1_in,
	output logic            word2_in,
	output logic            aes_frame,
	output logic            spdif_frame,
	output logic            optical_multichannel_input
);
	logic [8:0] pos_q = 9'h000;

	// Word clocks near 44.1 kHz and 48 kHz; a stopped word clock rests low
	initial begin
		word1_in = 1'b0;
		forever #11340 word1_in = en[0] & ~word1_in;
	end
	initial begin
		word2_in = 1'b0;
		forever #10420 word2_in = en[1] & ~word2_in;
	end

	// Link clock stands still unless a stream is sending
	initial begin
		link_clk = 1'b0;
		forever #32 link_clk = (|en[4:2]) & ~link_clk;
	end

	// Frame position: 326 link cycles for 48 kHz, half that for 96 kHz
	always @(posedge link_clk) pos_q <= (pos_q == 9'h145) ? 9'h000 : pos_q + 9'h001;

	assign aes_frame = en[2] && (pos_q == 9'h000 || pos_q == 9'h0a3);
	assign spdif_frame = en[3] && (pos_q == 9'h000 || pos_q == 9'h0a3);
	assign optical_multichannel_input = en[4] && pos_q == 9'h000;
endmodule : ref_sources

// ==== ref_watch.sv ====
// One reference input watcher: synchroniser, event detect, presence timeout.
// Assumes the raw input is asynchronous to sys_clk.
`timescale 1ns/1ps
`include "mcs_consts.svh"

module ref_watch #(
	parameter bit ANY_CHANGE = 1'b0
) (
	input  wire logic sys_clk,
	input  wire logic rstn,
	input  wire logic raw,
	output logic      ref_event,
	output logic      present
);

	logic        sync1_q;
	logic        sync2_q;
	logic        last_q;
	logic [11:0] idle_q;

	// Two-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			last_q  <= 1'b0;
		end else begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
			last_q  <= sync2_q;
		end
	end

	// Toggle streams count every change, word clocks only rising edges
	assign ref_event = ANY_CHANGE ? (sync2_q ^ last_q) : (sync2_q & ~last_q);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			idle_q  <= 12'h0000;
			present <= 1'b0;
		end else if (ref_event) begin
			idle_q  <= 12'h0000;
			present <= 1'b1;
		end else if (idle_q == 12'(`MCS_REF_TIMEOUT_CYC - 1)) begin
			present <= 1'b0;
		end else begin
			idle_q  <= idle_q + 12'h0001;
		end
	end

endmodule : ref_watch
